// ===== verilog/cogc_pkg.sv
package cogc_pkg;
   localparam int unsigned ADDR_W      = 5;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned REG_W       = 8;
   localparam int unsigned NUM_SRC     = 8;
   localparam int unsigned SYNC_STAGES = 3;

   localparam logic [4:0] OFS_CON0      = 5'h00;
   localparam logic [4:0] OFS_CON1      = 5'h04;
   localparam logic [4:0] OFS_RISE_EN   = 5'h08;
   localparam logic [4:0] OFS_RISE_MODE = 5'h0c;
   localparam logic [4:0] OFS_DBR       = 5'h10;
   localparam logic [4:0] OFS_DBF       = 5'h14;
   localparam logic [4:0] OFS_PHR       = 5'h18;
   localparam logic [4:0] OFS_STATUS    = 5'h1c;

   localparam int unsigned CON0_EN_BIT   = 7;
   localparam int unsigned CON0_LD_BIT   = 6;
   localparam int unsigned CON0_CS_LSB   = 3;
   localparam int unsigned CON0_MD_LSB   = 0;
   localparam int unsigned CON1_RISE_DEADBAND_SOURCE_BIT = 7;
   localparam int unsigned CON1_FALL_DEADBAND_SOURCE_BIT = 6;
   localparam int unsigned CON1_POL_LSB  = 0;

   localparam logic [7:0] CON0_MASK = 8'h9f;
   localparam logic [7:0] CON1_MASK = 8'hcf;
   localparam logic [7:0] RST_REG   = 8'h00;
   localparam logic [1:0] DIV4_LAST = 2'h3;

   localparam logic [1:0] CS_FOSC_DIV4 = 2'h0;
   localparam logic [1:0] CS_FOSC      = 2'h1;
   localparam logic [1:0] CS_FAST_OSC  = 2'h2;

   localparam logic [2:0] MD_STEER      = 3'h0;
   localparam logic [2:0] MD_SYNC_STEER = 3'h1;
   localparam logic [2:0] MD_FWD_FB     = 3'h2;
   localparam logic [2:0] MD_REV_FB     = 3'h3;
   localparam logic [2:0] MD_HALF_BR    = 3'h4;
   localparam logic [2:0] MD_PUSH_PULL  = 3'h5;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_PHASE  = 2'h1,
      ST_ACTIVE = 2'h3
   } cogc_state_e;
endpackage

// ===== verilog/cogc_src_if.sv
`timescale 1ns/100ps
interface cogc_src_if;
   logic en;
   logic mode;
   logic lvl;
   logic rise_edge;
   logic lvl_evt;
   modport src (input en, input mode, output lvl, output rise_edge, output lvl_evt);
   modport ctl (output en, output mode, input lvl, input rise_edge, input lvl_evt);
endinterface

// ===== verilog/cogc_rise_src.sv
`timescale 1ns/100ps
module cogc_rise_src #(
   parameter int unsigned STAGES = cogc_pkg::SYNC_STAGES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic src_pin,
   cogc_src_if.src  sif
);
   logic [STAGES-1:0] sync_r;
   logic              stable_r;
   logic              prev_r;
   wire               agree = (sync_r[STAGES-1] == sync_r[STAGES-2]);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sync_r   <= '0;
         stable_r <= 1'b0;
         prev_r   <= 1'b0;
      end else begin
         sync_r <= {sync_r[STAGES-2:0], src_pin};
         if (agree) begin
            stable_r <= sync_r[STAGES-1];
         end
         prev_r <= stable_r;
      end
   end

   // a disabled source is forced quiet here so nothing downstream sees it
   assign sif.lvl       = sif.en & stable_r;
   assign sif.rise_edge = sif.en & sif.mode & stable_r & ~prev_r;
   assign sif.lvl_evt   = sif.en & ~sif.mode & stable_r;

   property p_edge_mode;
      @(posedge sys_clk) disable iff (!rst_n)
      sif.en && sif.mode && stable_r && !prev_r |-> sif.rise_edge && !sif.lvl_evt;
   endproperty
   a_edge_mode: assert property (p_edge_mode) else $error("edge mode missed a rise");
endmodule

// ===== verilog/cogc_top.sv
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// Operation
// - enable bit 7 of control 0 runs the generator; clear keeps it off.
// - load bit 6 transfers phase, blanking, dead-band registers to buffers at next event; no blanking register is built here.
// - load bit reads zero once the transfer has finished.
// - clock field 10 fast oscillator, 01 system clock, 00 system clock / 4.
// - mode 101 push-pull, 100 half-bridge, 011 reverse, 010 forward full-bridge.
// - mode 001 synchronous steered, mode 000 steered output operation.
// - control 1 bit 7 picks delay chain or module clock for rising dead-band.
// - control 1 bit 6 picks delay chain or module clock for falling dead-band.
// - control 1 bits 3..0 make outputs D..A active low when set.
// - rising source bit 0 lets the selected input pin cause rising events.
// - rising source bits 1..4 enable comparators 1..4 as rising inputs.
// - rising source bits 5 and 6 enable capture/compare units 1 and 2.
// - rising source bit 7 enables the PWM unit 3 output.
// - unimplemented control bits read zero.
// - every implemented control bit resets to zero on any reset.
// - hardware clears load bit; while disabled count writes load buffers directly.
// - mode bit one means edge after phase delay, zero means level immediately.
module cogc_top (
   input  wire  logic        sys_clk,
   input  wire  logic        rst_n,
   input  wire  logic [4:0]  avs_address,
   input  wire  logic        avs_read,
   input  wire  logic        avs_write,
   input  wire  logic [31:0] avs_writedata,
   input  wire  logic [3:0]  avs_byteenable,
   output logic       [31:0] avs_readdata,
   output logic              avs_waitrequest,
   input  wire  logic [7:0]  rise_src_pin,
   input  wire  logic        fast_osc_clk,
   output logic       [3:0]  out_drive
);
   logic [7:0]  con0_r;
   logic        ld_r;
   logic [7:0]  con1_r;
   logic [7:0]  rise_en_r;
   logic [7:0]  rise_mode_r;
   logic [7:0]  dbr_r;
   logic [7:0]  dbf_r;
   logic [7:0]  phr_r;
   logic [7:0]  dbr_b;
   logic [7:0]  dbf_b;
   logic [7:0]  phr_b;
   logic        wait_r;
   logic [31:0] rdata_r;
   logic [2:0]  osc_r;
   logic        osc_st_r;
   logic [1:0]  div_r;
   logic [7:0]  ph_cnt_r;
   logic [7:0]  rdb_cnt_r;
   logic [7:0]  fdb_cnt_r;
   logic        pa_r;
   logic        pb_r;
   logic        pp_tog_r;
   logic [3:0]  out_r;
   logic [3:0]  drv;
   logic [7:0]  edge_v;
   logic [7:0]  lvl_evt_v;
   logic [7:0]  lvl_v;
   cogc_pkg::cogc_state_e state_r;
   cogc_pkg::cogc_state_e state_nxt;

   // bus decode
   wire       acc       = avs_read | avs_write;
   wire       wr_hit    = avs_write & ~wait_r & avs_byteenable[0];
   wire [7:0] wd8       = avs_writedata[7:0];
   wire       sel_con0  = (avs_address == cogc_pkg::OFS_CON0);
   wire       sel_con1  = (avs_address == cogc_pkg::OFS_CON1);
   wire       sel_ren   = (avs_address == cogc_pkg::OFS_RISE_EN);
   wire       sel_rmode = (avs_address == cogc_pkg::OFS_RISE_MODE);
   wire       sel_dbr   = (avs_address == cogc_pkg::OFS_DBR);
   wire       sel_dbf   = (avs_address == cogc_pkg::OFS_DBF);
   wire       sel_phr   = (avs_address == cogc_pkg::OFS_PHR);
   wire       sel_stat  = (avs_address == cogc_pkg::OFS_STATUS);
   wire       wr_con0   = wr_hit & sel_con0;
   wire       wr_dbr    = wr_hit & sel_dbr;
   wire       wr_dbf    = wr_hit & sel_dbf;
   wire       wr_phr    = wr_hit & sel_phr;

   // control fields
   wire       en_w   = con0_r[cogc_pkg::CON0_EN_BIT];
   wire [1:0] cs_w   = con0_r[cogc_pkg::CON0_CS_LSB +: 2];
   wire [2:0] md_w   = con0_r[cogc_pkg::CON0_MD_LSB +: 3];
   wire       rise_deadband_source_w = con1_r[cogc_pkg::CON1_RISE_DEADBAND_SOURCE_BIT];
   wire       fall_deadband_source_w = con1_r[cogc_pkg::CON1_FALL_DEADBAND_SOURCE_BIT];
   wire [3:0] pol_w  = con1_r[cogc_pkg::CON1_POL_LSB +: 4];

   // readback; the load bit is kept apart from the stored fields
   wire [7:0] con0_rd = con0_r | ({7'h00, ld_r} << cogc_pkg::CON0_LD_BIT);
   wire [7:0] stat_rd = {state_r, pa_r, pb_r, out_r};
   wire [7:0] rd_byte = sel_con0  ? con0_rd :
                        sel_con1  ? con1_r :
                        sel_ren   ? rise_en_r :
                        sel_rmode ? rise_mode_r :
                        sel_dbr   ? dbr_r :
                        sel_dbf   ? dbf_r :
                        sel_phr   ? phr_r :
                        sel_stat  ? stat_rd : cogc_pkg::RST_REG;

   // one wait state on every access, read data registered ahead of release
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wait_r  <= 1'b1;
         rdata_r <= '0;
      end else begin
         wait_r <= ~(acc & wait_r);
         if (avs_read & wait_r) begin
            rdata_r <= {24'h000000, rd_byte};
         end
      end
   end
   assign avs_waitrequest = wait_r;
   assign avs_readdata    = rdata_r;

   // module clock tick
   wire osc_rise = (osc_r[2] == osc_r[1]) & osc_r[2] & ~osc_st_r;
   wire mtick    = (cs_w == cogc_pkg::CS_FOSC)      ? 1'b1 :
                   (cs_w == cogc_pkg::CS_FOSC_DIV4) ? (div_r == cogc_pkg::DIV4_LAST) :
                   (cs_w == cogc_pkg::CS_FAST_OSC)  ? osc_rise : 1'b0;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         osc_r    <= '0;
         osc_st_r <= 1'b0;
         div_r    <= '0;
      end else begin
         osc_r <= {osc_r[1:0], fast_osc_clk};
         if (osc_r[2] == osc_r[1]) begin
            osc_st_r <= osc_r[2];
         end
         div_r <= div_r + 2'h1;
      end
   end

   // rising event sources
   genvar gi;
   generate
      for (gi = 0; gi < cogc_pkg::NUM_SRC; gi++) begin : g_src
         cogc_src_if sif ();
         assign sif.en        = rise_en_r[gi];
         assign sif.mode      = rise_mode_r[gi];
         assign edge_v[gi]    = sif.rise_edge;
         assign lvl_evt_v[gi] = sif.lvl_evt;
         assign lvl_v[gi]     = sif.lvl;
         cogc_rise_src u_src (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .src_pin (rise_src_pin[gi]),
            .sif     (sif.src)
         );
      end
   endgenerate

   wire any_edge = |edge_v;
   wire any_imm  = |lvl_evt_v;
   wire any_lvl  = |lvl_v;
   wire act      = (state_r == cogc_pkg::ST_ACTIVE);
   wire rise_evt = (state_nxt == cogc_pkg::ST_ACTIVE) & ~act;
   wire ph_done  = mtick & (ph_cnt_r <= 8'h01);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         cogc_pkg::ST_IDLE: begin
            if (any_imm) begin
               state_nxt = cogc_pkg::ST_ACTIVE;
            end else if (any_edge) begin
               state_nxt = (phr_b == 8'h00) ? cogc_pkg::ST_ACTIVE : cogc_pkg::ST_PHASE;
            end
         end
         cogc_pkg::ST_PHASE: begin
            if (any_imm | ph_done) begin
               state_nxt = cogc_pkg::ST_ACTIVE;
            end
         end
         cogc_pkg::ST_ACTIVE: begin
            if (!any_lvl) begin
               state_nxt = cogc_pkg::ST_IDLE;
            end
         end
         default: state_nxt = cogc_pkg::ST_IDLE;
      endcase
      if (!en_w) begin
         state_nxt = cogc_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_r  <= cogc_pkg::ST_IDLE;
         ph_cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         if (state_r != cogc_pkg::ST_PHASE) begin
            ph_cnt_r <= phr_b;
         end else if (mtick) begin
            ph_cnt_r <= ph_cnt_r - 8'h01;
         end
      end
   end

   // buffered transfer completes at the next rising event, or at once when off
   wire ld_done = ld_r & (rise_evt | ~en_w);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         con0_r      <= cogc_pkg::RST_REG;
         ld_r        <= 1'b0;
         con1_r      <= cogc_pkg::RST_REG;
         rise_en_r   <= cogc_pkg::RST_REG;
         rise_mode_r <= cogc_pkg::RST_REG;
         dbr_r       <= cogc_pkg::RST_REG;
         dbf_r       <= cogc_pkg::RST_REG;
         phr_r       <= cogc_pkg::RST_REG;
      end else begin
         if (wr_con0) begin
            con0_r <= wd8 & cogc_pkg::CON0_MASK;
         end
         // a software set in the same cycle beats the hardware clear
         if (wr_con0) begin
            ld_r <= wd8[cogc_pkg::CON0_LD_BIT];
         end else if (ld_done) begin
            ld_r <= 1'b0;
         end
         if (wr_hit & sel_con1) begin
            con1_r <= wd8 & cogc_pkg::CON1_MASK;
         end
         if (wr_hit & sel_ren) begin
            rise_en_r <= wd8;
         end
         if (wr_hit & sel_rmode) begin
            rise_mode_r <= wd8;
         end
         if (wr_dbr) begin
            dbr_r <= wd8;
         end
         if (wr_dbf) begin
            dbf_r <= wd8;
         end
         if (wr_phr) begin
            phr_r <= wd8;
         end
      end
   end

   // working buffers; blanking is not held in this block
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dbr_b <= '0;
         dbf_b <= '0;
         phr_b <= '0;
      end else if (!en_w && (wr_dbr || wr_dbf || wr_phr)) begin
         dbr_b <= wr_dbr ? wd8 : dbr_b;
         dbf_b <= wr_dbf ? wd8 : dbf_b;
         phr_b <= wr_phr ? wd8 : phr_b;
      end else if (ld_done) begin
         dbr_b <= dbr_r;
         dbf_b <= dbf_r;
         phr_b <= phr_r;
      end
   end

   // the delay chain is modelled as one step per system clock; only the
   // module clock path carries the one-tick uncertainty
   wire rstep = rise_deadband_source_w | mtick;
   wire fstep = fall_deadband_source_w | mtick;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdb_cnt_r <= '0;
         fdb_cnt_r <= '0;
         pa_r      <= 1'b0;
         pb_r      <= 1'b0;
         pp_tog_r  <= 1'b0;
      end else begin
         if (!act) begin
            rdb_cnt_r <= dbr_b;
         end else if (rstep && rdb_cnt_r != 8'h00) begin
            rdb_cnt_r <= rdb_cnt_r - 8'h01;
         end
         if (act) begin
            fdb_cnt_r <= dbf_b;
         end else if (fstep && fdb_cnt_r != 8'h00) begin
            fdb_cnt_r <= fdb_cnt_r - 8'h01;
         end
         pa_r <= en_w & act & (rdb_cnt_r == 8'h00);
         pb_r <= en_w & ~act & (fdb_cnt_r == 8'h00);
         if (rise_evt) begin
            pp_tog_r <= ~pp_tog_r;
         end
      end
   end

   // no steering register here, so the steered modes drive all four outputs
   always_comb begin
      case (md_w)
         cogc_pkg::MD_STEER:      drv = {4{pa_r}};
         cogc_pkg::MD_SYNC_STEER: drv = {4{pa_r}};
         cogc_pkg::MD_FWD_FB:     drv = {pa_r, 1'b0, 1'b0, 1'b1};
         cogc_pkg::MD_REV_FB:     drv = {1'b0, 1'b1, pa_r, 1'b0};
         cogc_pkg::MD_HALF_BR:    drv = {pb_r, pa_r, pb_r, pa_r};
         cogc_pkg::MD_PUSH_PULL: begin
            drv = {pa_r & ~pp_tog_r, pa_r & pp_tog_r, pa_r & ~pp_tog_r, pa_r & pp_tog_r};
         end
         default:                 drv = 4'h0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         out_r <= '0;
      end else begin
         out_r <= (en_w ? drv : 4'h0) ^ pol_w;
      end
   end
   assign out_drive = out_r;

   wire [1:0] pab_pol = {pb_r ^ pol_w[1], pa_r ^ pol_w[0]};

   property p_off_idle;
      @(posedge sys_clk) disable iff (!rst_n) !en_w |=> state_r == cogc_pkg::ST_IDLE;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("disabled block left idle");

   property p_off_out;
      @(posedge sys_clk) disable iff (!rst_n) !en_w ##1 $stable(pol_w) |-> out_r == pol_w;
   endproperty
   a_off_out: assert property (p_off_out) else $error("disabled outputs not inactive");

   property p_ld_clear;
      @(posedge sys_clk) disable iff (!rst_n) ld_r && en_w && rise_evt && !wr_con0 |=> !ld_r;
   endproperty
   a_ld_clear: assert property (p_ld_clear) else $error("load bit not cleared");

   property p_ld_xfer;
      @(posedge sys_clk) disable iff (!rst_n)
      ld_r && en_w && rise_evt ##1 !$past(wr_phr) |-> phr_b == $past(phr_r);
   endproperty
   a_ld_xfer: assert property (p_ld_xfer) else $error("buffers not loaded");

   property p_direct;
      @(posedge sys_clk) disable iff (!rst_n) !en_w && wr_dbr |=> dbr_b == $past(wd8);
   endproperty
   a_direct: assert property (p_direct) else $error("direct buffer load missing");

   property p_div4;
      @(posedge sys_clk) disable iff (!rst_n)
      cs_w == cogc_pkg::CS_FOSC_DIV4 && mtick && !wr_con0 |=>
         (cs_w != cogc_pkg::CS_FOSC_DIV4 || !mtick) [*3];
   endproperty
   a_div4: assert property (p_div4) else $error("divide by four tick wrong");

   property p_rsv_bits;
      @(posedge sys_clk) disable iff (!rst_n)
      avs_read && wait_r && (sel_con0 || sel_con1) |=> avs_readdata[5:4] == 2'h0
         || $past(sel_con0) && avs_readdata[5] == 1'b0;
   endproperty
   a_rsv_bits: assert property (p_rsv_bits) else $error("reserved bits read set");

   property p_reset;
      @(posedge sys_clk) $rose(rst_n) |-> con0_rd == 8'h00 && con1_r == 8'h00 && rise_en_r == 8'h00;
   endproperty
   a_reset: assert property (p_reset) else $error("control not zero after reset");

   property p_or;
      @(posedge sys_clk) disable iff (!rst_n)
      en_w && state_r == cogc_pkg::ST_IDLE && any_imm |=> state_r == cogc_pkg::ST_ACTIVE;
   endproperty
   a_or: assert property (p_or) else $error("level source did not fire");

   property p_gate;
      @(posedge sys_clk) disable iff (!rst_n) ((edge_v | lvl_evt_v | lvl_v) & ~rise_en_r) == 8'h00;
   endproperty
   a_gate: assert property (p_gate) else $error("disabled source active");

   property p_rdb;
      @(posedge sys_clk) disable iff (!rst_n)
      act && rise_deadband_source_w && rdb_cnt_r != 8'h00 |=> !act || rdb_cnt_r == $past(rdb_cnt_r) - 8'h01;
   endproperty
   a_rdb: assert property (p_rdb) else $error("rise dead-band chain step wrong");

   property p_fdb;
      @(posedge sys_clk) disable iff (!rst_n)
      !act && !fall_deadband_source_w && !mtick && fdb_cnt_r != 8'h00 |=> act || $stable(fdb_cnt_r);
   endproperty
   a_fdb: assert property (p_fdb) else $error("fall dead-band ignored module clock");

   property p_half;
      @(posedge sys_clk) disable iff (!rst_n)
      en_w && md_w == cogc_pkg::MD_HALF_BR |=> out_r[1:0] == $past(pab_pol);
   endproperty
   a_half: assert property (p_half) else $error("half-bridge outputs wrong");

   property p_sync;
      @(posedge sys_clk) disable iff (!rst_n)
      en_w && md_w == cogc_pkg::MD_SYNC_STEER |=> out_r[0] == $past(pab_pol[0]);
   endproperty
   a_sync: assert property (p_sync) else $error("steered output wrong");

   c_phase: cover property (@(posedge sys_clk) state_r == cogc_pkg::ST_PHASE ##[1:20] act);
   c_ld: cover property (@(posedge sys_clk) ld_r && rise_evt && en_w);
   c_pp: cover property (@(posedge sys_clk) md_w == cogc_pkg::MD_PUSH_PULL && $rose(pp_tog_r));
endmodule

// ===== test/cogc_evt_model.sv
`timescale 1ns/100ps
module cogc_evt_model (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] lvl_cmd,
   output logic      [7:0] rise_src_pin,
   output logic            fast_osc_clk
);
   // the event sources stay quiet while the chip is held in reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rise_src_pin <= 8'h00;
      end else begin
         rise_src_pin <= lvl_cmd;
      end
   end

   // free running and slow on purpose, so a module clock on it is easy to tell apart
   initial begin
      fast_osc_clk = 1'b0;
      #37;
      forever #800 fast_osc_clk = ~fast_osc_clk;
   end
endmodule

// ===== test/cogc_top_tb_top.sv
`timescale 1ns/100ps
module cogc_top_tb_top;
   logic        sys_clk;
   logic        rst_n;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [7:0]  rise_src_pin;
   logic        fast_osc_clk;
   logic [3:0]  out_drive;
   logic [7:0]  lvl_cmd;
   int          error_cnt;
   int          n_tests;

   cogc_top cogc_top_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .rise_src_pin(rise_src_pin), .fast_osc_clk(fast_osc_clk), .out_drive(out_drive));

   cogc_evt_model cogc_evt_model_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .lvl_cmd(lvl_cmd),
      .rise_src_pin(rise_src_pin), .fast_osc_clk(fast_osc_clk));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      int i;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      avs_read <= ~wr;
      avs_write <= wr;
      i = 0;
      do begin
         @(posedge sys_clk);
         i++;
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      // one wait state is promised on every access; a hang is left to the watchdog
      chk("bus answer", 32'(i), 32'h2);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'h1, q);
   endtask

   task automatic rd(input string nm, input logic [4:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, 4'hf, q);
      chk(nm, q, {24'h0, e});
   endtask

   task automatic pins(input logic [7:0] v);
      @(posedge sys_clk);
      lvl_cmd <= v;
   endtask

   task automatic wait_out(input logic [3:0] e, output int n);
      n = 0;
      while (out_drive !== e && n < 300) begin
         @(posedge sys_clk);
         n++;
      end
      chk("out_drive", {28'h0, out_drive}, {28'h0, e});
   endtask

   // counts go in while disabled so they reach the buffers directly
   task automatic cfg(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] en,
                      input logic [7:0] md, input logic [7:0] db, input logic [7:0] ph);
      wr(cogc_pkg::OFS_CON0, 8'h00);
      wr(cogc_pkg::OFS_CON1, c1);
      wr(cogc_pkg::OFS_RISE_EN, en);
      wr(cogc_pkg::OFS_RISE_MODE, md);
      wr(cogc_pkg::OFS_DBR, db);
      wr(cogc_pkg::OFS_DBF, db);
      wr(cogc_pkg::OFS_PHR, ph);
      wr(cogc_pkg::OFS_CON0, c0);
   endtask

   task automatic t_regs;
      logic [31:0] q;
      rd("ctrl0 reset", cogc_pkg::OFS_CON0, 8'h00);
      rd("ctrl1 reset", cogc_pkg::OFS_CON1, 8'h00);
      rd("rise en reset", cogc_pkg::OFS_RISE_EN, 8'h00);
      wr(cogc_pkg::OFS_STATUS, 8'hff);
      rd("status", cogc_pkg::OFS_STATUS, 8'h00);
      wr(cogc_pkg::OFS_CON0, 8'h2c);
      rd("ctrl0 gap", cogc_pkg::OFS_CON0, 8'h0c);
      wr(cogc_pkg::OFS_CON1, 8'hff);
      rd("ctrl1 gap", cogc_pkg::OFS_CON1, 8'hcf);
      wr(cogc_pkg::OFS_RISE_EN, 8'ha5);
      bus(1'b1, cogc_pkg::OFS_RISE_EN, 8'h5a, 4'he, q);
      rd("rise en", cogc_pkg::OFS_RISE_EN, 8'ha5);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd("ctrl0 rereset", cogc_pkg::OFS_CON0, 8'h00);
      rd("ctrl1 rereset", cogc_pkg::OFS_CON1, 8'h00);
      rd("rise en rereset", cogc_pkg::OFS_RISE_EN, 8'h00);
      $display("test regs done");
   endtask

   task automatic t_src;
      int n;
      cfg(8'h88, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(cogc_pkg::OFS_RISE_EN, 8'h01 << i);
         pins(~(8'h01 << i));
         repeat (12) @(posedge sys_clk);
         chk("masked src", {28'h0, out_drive}, 32'h0);
         pins(8'hff);
         wait_out(4'hf, n);
         pins(8'h00);
         wait_out(4'h0, n);
      end
      wr(cogc_pkg::OFS_RISE_EN, 8'h09);
      pins(8'h08);
      wait_out(4'hf, n);
      pins(8'h00);
      wait_out(4'h0, n);
      wr(cogc_pkg::OFS_CON0, 8'h08);
      pins(8'hff);
      repeat (12) @(posedge sys_clk);
      chk("disabled", {28'h0, out_drive}, 32'h0);
      pins(8'h00);
      $display("test sources done");
   endtask

   task automatic t_pol;
      int n;
      cfg(8'h88, 8'h05, 8'h01, 8'h00, 8'h00, 8'h00);
      wait_out(4'h5, n);
      pins(8'hff);
      wait_out(4'ha, n);
      pins(8'h00);
      wait_out(4'h5, n);
      $display("test polarity done");
   endtask

   task automatic t_modes;
      logic [3:0]  exp [5] = '{4'hf, 4'hf, 4'h9, 4'h6, 4'h5};
      logic [3:0]  pp;
      logic [31:0] q;
      int          n;
      cfg(8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00);
      for (int m = 0; m < 5; m++) begin
         wr(cogc_pkg::OFS_CON0, {5'h11, 3'(m)});
         pins(8'hff);
         wait_out(exp[m], n);
         bus(1'b0, cogc_pkg::OFS_STATUS, 8'h00, 4'hf, q);
         chk("state", {30'h0, q[7:6]}, 32'h3);
         pins(8'h00);
         repeat (20) @(posedge sys_clk);
         wr(cogc_pkg::OFS_CON0, 8'h00);
      end
      wr(cogc_pkg::OFS_CON0, 8'h8d);
      // two rising events in a row must drive opposite output pairs
      for (int k = 0; k < 2; k++) begin
         pins(8'hff);
         repeat (30) @(posedge sys_clk);
         chk("push pull", {31'h0, out_drive === 4'h5 || out_drive === 4'ha}, 32'h1);
         if (k == 1) begin
            chk("push pull swap", {28'h0, out_drive}, {28'h0, ~pp});
         end
         pp = out_drive;
         pins(8'h00);
         repeat (20) @(posedge sys_clk);
      end
      $display("test modes done");
   endtask

   task automatic t_load;
      int n;
      wr(cogc_pkg::OFS_CON0, 8'h40);
      rd("load off", cogc_pkg::OFS_CON0, 8'h00);
      cfg(8'hc8, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00);
      rd("load held", cogc_pkg::OFS_CON0, 8'hc8);
      pins(8'hff);
      wait_out(4'hf, n);
      rd("load done", cogc_pkg::OFS_CON0, 8'h88);
      pins(8'h00);
      wait_out(4'h0, n);
      $display("test load done");
   endtask

   // latency of one rising and one falling event in half-bridge mode
   task automatic lat(input logic [7:0] c0, output int r, output int f);
      wr(cogc_pkg::OFS_CON0, c0);
      pins(8'hff);
      wait_out(4'h5, r);
      pins(8'h00);
      wait_out(4'ha, f);
   endtask

   task automatic t_time;
      int r1, r2, r3, r4, r5, f4, f5, f;
      cfg(8'h8c, 8'h00, 8'h01, 8'h01, 8'h00, 8'h04);
      lat(8'h8c, r1, f);
      lat(8'h84, r2, f);
      lat(8'h94, r3, f);
      chk("div4 slower", {31'h0, r2 > r1}, 32'h1);
      chk("osc slower", {31'h0, r3 > r2}, 32'h1);
      cfg(8'h84, 8'h00, 8'h01, 8'h00, 8'h08, 8'h00);
      lat(8'h84, r4, f4);
      cfg(8'h84, 8'hc0, 8'h01, 8'h00, 8'h08, 8'h00);
      lat(8'h84, r5, f5);
      chk("rise chain", {31'h0, r4 > r5}, 32'h1);
      chk("fall chain", {31'h0, f4 > f5}, 32'h1);
      $display("test timing done");
   endtask

   initial begin
      rst_n = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      lvl_cmd = 8'h00;
      error_cnt = 0;
      n_tests = 0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_regs;
      t_src;
      t_pol;
      t_modes;
      t_load;
      t_time;
      conclude;
   end

   initial begin
      repeat (60000) @(posedge sys_clk);
      error_cnt++;
      $display("watchdog expired");
      conclude;
   end
endmodule
